// ===== rtl/pcpd_map.svh
// register offsets, field positions, write masks and reset values of the pll config bank
`ifndef PCPD_MAP_SVH
`define PCPD_MAP_SVH

// byte addresses on the management port
`define PCPD_ADDR_ALF 16'h0068
`define PCPD_ADDR_LML 16'h0069
`define PCPD_ADDR_MOL 16'h006A
`define PCPD_ADDR_FIX 16'h006B
`define PCPD_ADDR_XDB 16'h006C
`define PCPD_ADDR_RIP 16'h006D
`define PCPD_ADDR_SPR 16'h006E
`define PCPD_ADDR_OPC 16'h006F
`define PCPD_ADDR_LCP 16'h0070

// writable bits per register; reserved bits are not stored
`define PCPD_MASK_ALF 8'hFF
`define PCPD_MASK_LML 8'h9B
`define PCPD_MASK_MOL 8'hFF
`define PCPD_MASK_XDB 8'h01
`define PCPD_MASK_RIP 8'h03
`define PCPD_MASK_OPC 8'h0F
`define PCPD_MASK_LCP 8'h07

// reset values
`define PCPD_RST_ALF 8'h8B
`define PCPD_RST_LML 8'h02
`define PCPD_RST_MOL 8'h0B
`define PCPD_RST_XDB 8'h00
`define PCPD_RST_RIP 8'h00
`define PCPD_RST_OPC 8'h00
`define PCPD_RST_LCP 8'h00

// field positions
`define PCPD_CPC_LSB 5
`define PCPD_RSS_LSB 3
`define PCPD_LCS_LSB 1
`define PCPD_SPS_BIT 0
`define PCPD_LRM_BIT 7
`define PCPD_TDC_BIT 4
`define PCPD_XOS_BIT 3
`define PCPD_LCW_BIT 1
`define PCPD_LMO_BIT 0
`define PCPD_OMS_LSB 5
`define PCPD_LMV_LSB 0
`define PCPD_DLO_BIT 2
`define PCPD_MOD_BIT 1
`define PCPD_CAL_BIT 0

// lock counter widths in bits
`define PCPD_LOCK_BITS_WIDE 5'h14
`define PCPD_LOCK_BITS_NARROW 5'h10

`endif

// ===== rtl/pcpd_pkg.sv
// types shared by the pll config bank modules
`default_nettype none
package pcpd_pkg;
   // oscillator picked in manual lock mode
   typedef enum logic [2:0] {
      PCPD_OSC0 = 3'h0,
      PCPD_OSC1 = 3'h1
   } pcpd_osc_t;
   typedef logic [7:0] pcpd_byte_t;
   typedef logic [15:0] pcpd_addr_t;
endpackage : pcpd_pkg
`default_nettype wire

// ===== rtl/pcpd_cfg_if.sv
// stored fields passed from the register bank to the mode resolver
`timescale 1ns/1ps
`default_nettype none
interface pcpd_cfg_if;
   logic [2:0] charge_pump_current;
   logic lock_manual_override;
   logic [2:0] osc_manual_sel;
   logic [4:0] lock_manual_value;
   logic lock_count_width;
   logic crystal_only_synth;
   logic digital_loop_off;
   modport bank (
      output charge_pump_current, lock_manual_override, osc_manual_sel,
      output lock_manual_value, lock_count_width, crystal_only_synth, digital_loop_off
   );
   modport resolve (
      input charge_pump_current, lock_manual_override, osc_manual_sel,
      input lock_manual_value, lock_count_width, crystal_only_synth, digital_loop_off
   );
endinterface : pcpd_cfg_if
`default_nettype wire

// ===== rtl/pcpd_mode_resolve.sv
// turns stored lock and loop fields into the effective controls the pll uses
`timescale 1ns/1ps
`default_nettype none
`include "pcpd_map.svh"
module pcpd_mode_resolve
   import pcpd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // stored fields
   pcpd_cfg_if.resolve cfg,
   // effective controls
   output logic manual_lock_active,
   output pcpd_osc_t manual_osc,
   output logic osc_code_reserved,
   output logic [4:0] lock_ctrl_value,
   output logic [4:0] lock_count_bits,
   output logic [3:0] pump_current_steps,
   output logic free_run_hint
);
   logic [3:0] steps_nxt;

   // pump current in units of the lowest step, code 000 being one step
   assign steps_nxt = {1'b0, cfg.charge_pump_current} + 4'h1;

   // manual settings only reach the loop while manual override is on
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         manual_lock_active <= 1'b0;
         manual_osc <= PCPD_OSC0;
         osc_code_reserved <= 1'b0;
         lock_ctrl_value <= 5'h00;
      end else begin
         manual_lock_active <= cfg.lock_manual_override; // RULE9
         osc_code_reserved <= cfg.osc_manual_sel[2:1] != 2'h0; // RULE10
         // reserved oscillator codes fall back to oscillator zero
         manual_osc <= (cfg.lock_manual_override && cfg.osc_manual_sel == 3'h1) ?
                       PCPD_OSC1 : PCPD_OSC0; // RULE10
         lock_ctrl_value <= cfg.lock_manual_override ? cfg.lock_manual_value : 5'h00; // RULE11
      end
   end

   // lock counter width and pump current scale
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lock_count_bits <= `PCPD_LOCK_BITS_NARROW;
         pump_current_steps <= 4'h5;
         free_run_hint <= 1'b0;
      end else begin
         lock_count_bits <= cfg.lock_count_width ? `PCPD_LOCK_BITS_NARROW :
                            `PCPD_LOCK_BITS_WIDE; // RULE8
         pump_current_steps <= steps_nxt; // RULE1
         // crystal-only synthesis with the digital loop still active
         free_run_hint <= cfg.crystal_only_synth && !cfg.digital_loop_off; // RULE6
      end
   end
endmodule : pcpd_mode_resolve
`default_nettype wire

// ===== rtl/pcpd_regs.sv
// pll analog loop and power-down configuration register bank, bytes 0x68 to 0x70
// Notes on behaviour
// RULE1: pump current code, eight steps, default 100
// RULE2: series resistor code, four values, default 01
// RULE3: loop capacitor code, four values, default 01
// RULE4: second pole bit picks resistance, default one
// RULE5: one disables time-to-digital converter
// RULE6: one selects crystal-only synthesis
// RULE7: software forces free-run before crystal-only mode
// RULE8: lock counter 20 bits at zero, 16 at one
// RULE9: manual override one applies manual lock settings
// RULE10: oscillator code 000 or 001, others reserved
// RULE11: manual lock value, default 01011
// RULE12: reserved bits written zero, read undefined
// RULE13: lol release waits for stable outputs at one
// RULE14: crystal doubler off uses raw crystal
// RULE15: two input reference disable bits, default zero
// RULE16: four output disable bits tristate drivers
// RULE17: one disables the digital loop
// RULE18: one disables delta-sigma modulator
// RULE19: one holds analog calibration logic
// RULE20: byte 0x68 holds pump, resistor, cap, pole
// RULE21: byte 0x6F holds output disables bits 3-0
// RULE22: reset restores defaults, byte wise access
`timescale 1ns/1ps
`default_nettype none
`include "pcpd_map.svh"
module pcpd_regs
   import pcpd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // management port byte access
   input wire logic [15:0] mgmt_addr,
   input wire logic mgmt_wr_en,
   input wire logic [7:0] mgmt_wdata,
   input wire logic mgmt_rd_en,
   output logic [7:0] mgmt_rdata,
   output logic mgmt_rd_valid,
   output logic mgmt_addr_hit,
   // analog loop filter
   output logic [2:0] charge_pump_current,
   output logic [1:0] series_resistor_sel,
   output logic [1:0] loop_cap_sel,
   output logic second_pole_sel,
   // loop mode and lock
   output logic lol_release_mode,
   output logic time_digital_conv_off,
   output logic crystal_only_synth,
   output logic lock_count_width,
   output logic lock_manual_override,
   output logic [2:0] osc_manual_sel,
   output logic [4:0] lock_manual_value,
   // power down
   output logic xtal_doubler_off,
   output logic ref_input0_off,
   output logic ref_input1_off,
   output logic [3:0] output_off,
   output logic digital_loop_off,
   output logic modulator_off,
   output logic calib_hold,
   // effective controls
   output logic manual_lock_active,
   output pcpd_osc_t manual_osc,
   output logic osc_code_reserved,
   output logic [4:0] lock_ctrl_value,
   output logic [4:0] lock_count_bits,
   output logic [3:0] pump_current_steps,
   output logic free_run_hint
);
   localparam int NREG = 7;
   localparam pcpd_addr_t REG_ADDR [NREG] = '{
      `PCPD_ADDR_ALF, `PCPD_ADDR_LML, `PCPD_ADDR_MOL, `PCPD_ADDR_XDB,
      `PCPD_ADDR_RIP, `PCPD_ADDR_OPC, `PCPD_ADDR_LCP
   };
   localparam pcpd_byte_t REG_MASK [NREG] = '{
      `PCPD_MASK_ALF, `PCPD_MASK_LML, `PCPD_MASK_MOL, `PCPD_MASK_XDB,
      `PCPD_MASK_RIP, `PCPD_MASK_OPC, `PCPD_MASK_LCP
   };
   localparam pcpd_byte_t REG_RST [NREG] = '{
      `PCPD_RST_ALF, `PCPD_RST_LML, `PCPD_RST_MOL, `PCPD_RST_XDB,
      `PCPD_RST_RIP, `PCPD_RST_OPC, `PCPD_RST_LCP
   };

   pcpd_byte_t reg_r [NREG];
   logic [NREG-1:0] sel;
   logic reserved_hit;
   pcpd_byte_t rdata_nxt;
   logic hit_nxt;

   // the two reserved bytes answer as mapped but store nothing
   assign reserved_hit = (mgmt_addr == `PCPD_ADDR_FIX) || (mgmt_addr == `PCPD_ADDR_SPR);

   // one storage byte per mapped address
   generate
      for (genvar i = 0; i < NREG; i++) begin : g_reg
         assign sel[i] = (mgmt_addr == REG_ADDR[i]);
         // reserved bits are masked off so a stray one cannot steer anything
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               reg_r[i] <= REG_RST[i]; // RULE22
            end else if (mgmt_wr_en && sel[i]) begin
               reg_r[i] <= mgmt_wdata & REG_MASK[i]; // RULE12
            end
         end
      end
   endgenerate

   // read multiplexer; reserved positions read back as zero
   always_comb begin
      rdata_nxt = 8'h00;
      hit_nxt = reserved_hit;
      for (int k = 0; k < NREG; k++) begin
         if (sel[k]) begin
            rdata_nxt = reg_r[k]; // RULE22
            hit_nxt = 1'b1;
         end
      end
   end

   // read data is registered, one cycle after the strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mgmt_rdata <= 8'h00;
         mgmt_addr_hit <= 1'b0;
      end else if (mgmt_rd_en) begin
         mgmt_rdata <= rdata_nxt;
         mgmt_addr_hit <= hit_nxt;
      end
   end

   // read valid pulse
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mgmt_rd_valid <= 1'b0;
      end else begin
         mgmt_rd_valid <= mgmt_rd_en;
      end
   end

   // byte 0x68: analog loop filter
   assign charge_pump_current = reg_r[0][`PCPD_CPC_LSB +: 3]; // RULE1
   assign series_resistor_sel = reg_r[0][`PCPD_RSS_LSB +: 2]; // RULE2
   assign loop_cap_sel = reg_r[0][`PCPD_LCS_LSB +: 2]; // RULE3
   assign second_pole_sel = reg_r[0][`PCPD_SPS_BIT]; // RULE4

   // byte 0x69: loop mode and lock control
   assign lol_release_mode = reg_r[1][`PCPD_LRM_BIT]; // RULE13
   assign time_digital_conv_off = reg_r[1][`PCPD_TDC_BIT]; // RULE5
   assign crystal_only_synth = reg_r[1][`PCPD_XOS_BIT]; // RULE6
   assign lock_count_width = reg_r[1][`PCPD_LCW_BIT]; // RULE8
   assign lock_manual_override = reg_r[1][`PCPD_LMO_BIT]; // RULE9

   // byte 0x6A: manual oscillator and lock value
   assign osc_manual_sel = reg_r[2][`PCPD_OMS_LSB +: 3]; // RULE10
   assign lock_manual_value = reg_r[2][`PCPD_LMV_LSB +: 5]; // RULE11

   // bytes 0x6C to 0x70: power down
   assign xtal_doubler_off = reg_r[3][0]; // RULE14
   assign ref_input0_off = reg_r[4][0]; // RULE15
   assign ref_input1_off = reg_r[4][1]; // RULE15
   assign output_off = reg_r[5][3:0]; // RULE21
   assign digital_loop_off = reg_r[6][`PCPD_DLO_BIT]; // RULE17
   assign modulator_off = reg_r[6][`PCPD_MOD_BIT]; // RULE18
   assign calib_hold = reg_r[6][`PCPD_CAL_BIT]; // RULE19

   // stored fields travel to the resolver
   pcpd_cfg_if cfg_bus ();
   assign cfg_bus.charge_pump_current = charge_pump_current;
   assign cfg_bus.lock_manual_override = lock_manual_override;
   assign cfg_bus.osc_manual_sel = osc_manual_sel;
   assign cfg_bus.lock_manual_value = lock_manual_value;
   assign cfg_bus.lock_count_width = lock_count_width;
   assign cfg_bus.crystal_only_synth = crystal_only_synth;
   assign cfg_bus.digital_loop_off = digital_loop_off;

   // effective controls lag the stored fields by one cycle
   pcpd_mode_resolve u_resolve (
      .sys_clk (sys_clk),
      .rst (rst),
      .cfg (cfg_bus),
      .manual_lock_active (manual_lock_active),
      .manual_osc (manual_osc),
      .osc_code_reserved (osc_code_reserved),
      .lock_ctrl_value (lock_ctrl_value),
      .lock_count_bits (lock_count_bits),
      .pump_current_steps (pump_current_steps),
      .free_run_hint (free_run_hint)
   );

   // write to one address followed by a read of it
   sequence s_write_at(logic [15:0] a);
      mgmt_wr_en && mgmt_addr == a;
   endsequence

   sequence s_read_at(logic [15:0] a);
      mgmt_rd_en && !mgmt_wr_en && mgmt_addr == a;
   endsequence

   // defaults hold in the cycle after reset is released
   a_reset_defaults: assert property (@(posedge sys_clk) // RULE22
      $past(rst) && !rst |-> charge_pump_current == 3'h4 && series_resistor_sel == 2'h1
         && loop_cap_sel == 2'h1 && second_pole_sel && lock_count_width
         && lock_manual_value == 5'h0B && output_off == 4'h0 && !calib_hold) // RULE22
      else $error("bank not at defaults after reset");

   // write to byte 0x68 lands in the four filter fields
   a_filter_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
      s_write_at(`PCPD_ADDR_ALF) |=> {charge_pump_current, series_resistor_sel,
         loop_cap_sel, second_pole_sel} == $past(mgmt_wdata)) // RULE20
      else $error("filter byte write not stored");

   // output disable write keeps only the low four bits
   a_output_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE16
      s_write_at(`PCPD_ADDR_OPC) |=> output_off == $past(mgmt_wdata[3:0])) // RULE16
      else $error("output disable write not stored");

   // written byte reads back with reserved bits at zero
   a_readback_mask: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
      s_write_at(`PCPD_ADDR_LML) ##1 s_read_at(`PCPD_ADDR_LML) |=>
         mgmt_rdata == ($past(mgmt_wdata, 2) & 8'h9B)) // RULE12
      else $error("mode byte readback wrong");

   // loop power byte 0x70 reads back in its documented positions
   a_power_read: assert property (@(posedge sys_clk) disable iff (rst) // RULE17
      s_read_at(`PCPD_ADDR_LCP) |=> mgmt_rdata == {5'h00, $past(digital_loop_off),
         $past(modulator_off), $past(calib_hold)}) // RULE17
      else $error("loop power byte read wrong");

   // reference disable bits follow writes
   a_ref_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
      s_write_at(`PCPD_ADDR_RIP) |=> {ref_input1_off, ref_input0_off}
         == $past(mgmt_wdata[1:0])) // RULE15
      else $error("reference disable write not stored");

   // a read strobe gives exactly one valid pulse
   a_read_pulse: assert property (@(posedge sys_clk) disable iff (rst) // RULE22
      mgmt_rd_en |=> mgmt_rd_valid ##1 (mgmt_rd_valid == $past(mgmt_rd_en)))
      else $error("read valid pulse wrong");

   // unmapped addresses read zero and report no hit
   a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE22
      mgmt_rd_en && mgmt_addr == 16'h0071 |=> mgmt_rdata == 8'h00 && !mgmt_addr_hit)
      else $error("unmapped read not zero");

   // fields stay put without a write
   a_hold_no_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
      !mgmt_wr_en |=> $stable(lol_release_mode) && $stable(xtal_doubler_off)
         && $stable(time_digital_conv_off) && $stable(modulator_off)) // RULE13
      else $error("field changed without write");

   // manual override reaches the effective controls one cycle later
   a_manual_gate: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
      lock_manual_override |=> manual_lock_active && lock_ctrl_value == $past(lock_manual_value))
      else $error("manual lock settings not applied");

   // automatic mode keeps oscillator zero and a zero lock value
   a_auto_mode: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
      !lock_manual_override |=> manual_osc == PCPD_OSC0 && lock_ctrl_value == 5'h00) // RULE11
      else $error("manual value leaked in automatic mode");

   // reserved oscillator codes are flagged and fall back
   a_osc_reserved: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
      osc_manual_sel[2:1] != 2'h0 |=> osc_code_reserved && manual_osc == PCPD_OSC0) // RULE10
      else $error("reserved oscillator code not caught");

   // lock counter width follows the width bit
   a_lock_width: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
      !lock_count_width |=> lock_count_bits == `PCPD_LOCK_BITS_WIDE) // RULE8
      else $error("lock counter width wrong");

   // pump current scale is code plus one steps
   a_pump_steps: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
      charge_pump_current == 3'h7 |=> pump_current_steps == 4'h8) // RULE1
      else $error("pump current scale wrong");

   // crystal-only mode with the loop on raises the hint
   a_free_run: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
      crystal_only_synth && !digital_loop_off |=> free_run_hint) // RULE6
      else $error("crystal-only hint missing");

   // capacitor code and second pole track a filter write
   a_cap_pole: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
      s_write_at(`PCPD_ADDR_ALF) ##1 !mgmt_wr_en |=> loop_cap_sel == $past(mgmt_wdata[2:1], 2)
         && second_pole_sel == $past(mgmt_wdata[0], 2)) // RULE3
      else $error("capacitor or pole field lost");

   // doubler bit on byte 0x6C
   a_doubler: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
      s_write_at(`PCPD_ADDR_XDB) |=> xtal_doubler_off == $past(mgmt_wdata[0])) // RULE14
      else $error("doubler bit not stored");

   // resistor code on byte 0x68 bits 4 to 3
   a_resistor: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
      s_write_at(`PCPD_ADDR_ALF) |=> series_resistor_sel == $past(mgmt_wdata[4:3])) // RULE2
      else $error("resistor code not stored");

   // converter-off bit on byte 0x69 bit 4
   a_tdc_bit: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
      s_write_at(`PCPD_ADDR_LML) |=> time_digital_conv_off == $past(mgmt_wdata[4])) // RULE5
      else $error("converter disable not stored");

   // calibration hold and modulator bits on byte 0x70
   a_calib_bits: assert property (@(posedge sys_clk) disable iff (rst) // RULE19
      s_write_at(`PCPD_ADDR_LCP) |=> calib_hold == $past(mgmt_wdata[0])
         && modulator_off == $past(mgmt_wdata[1])) // RULE19
      else $error("calibration or modulator bit not stored");

   // second pole default-one survives only until written
   a_pole_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
      s_write_at(`PCPD_ADDR_ALF) ##0 !mgmt_wdata[0] |=> !second_pole_sel) // RULE4
      else $error("second pole not cleared by write");

   // modulator bit alone
   a_mod_bit: assert property (@(posedge sys_clk) disable iff (rst) // RULE18
      s_write_at(`PCPD_ADDR_LCP) ##0 mgmt_wdata[1] |=> modulator_off) // RULE18
      else $error("modulator disable not set");

   // reserved byte 0x6E stores nothing and reads zero
   a_spare_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
      s_read_at(`PCPD_ADDR_SPR) |=> mgmt_rdata == 8'h00 && mgmt_addr_hit) // RULE12
      else $error("reserved byte not zero");

   // read data and hit hold between reads, so software may sample late
   a_rdata_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE22
      !mgmt_rd_en |=> $stable(mgmt_rdata) && $stable(mgmt_addr_hit))
      else $error("read data changed without a read");

   // no valid pulse without a read strobe
   a_valid_idle: assert property (@(posedge sys_clk) disable iff (rst) // RULE22
      !mgmt_rd_en |=> !mgmt_rd_valid)
      else $error("read valid without a read");

   // mode byte write lands in its five fields
   a_mode_fields: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
      s_write_at(`PCPD_ADDR_LML) |=> {lol_release_mode, time_digital_conv_off,
         crystal_only_synth, lock_count_width, lock_manual_override}
         == $past({mgmt_wdata[7], mgmt_wdata[4:3], mgmt_wdata[1:0]}))
      else $error("mode byte write not stored");

   // manual oscillator code and lock value land in byte 0x6A
   a_manual_fields: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
      s_write_at(`PCPD_ADDR_MOL) |=> osc_manual_sel == $past(mgmt_wdata[7:5])
         && lock_manual_value == $past(mgmt_wdata[4:0]))
      else $error("manual byte write not stored");
endmodule : pcpd_regs
`default_nettype wire

// ===== test/pcpd_regs_bench.sv
// self-checking bench for the pll config and power-down register bank
`timescale 1ns/1ps
`default_nettype none
`include "pcpd_map.svh"
`define PCPD_CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module pcpd_regs_bench
   import pcpd_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] mgmt_addr = 16'h0000;
   logic mgmt_wr_en = 1'b0;
   logic [7:0] mgmt_wdata = 8'h00;
   logic mgmt_rd_en = 1'b0;
   logic [7:0] mgmt_rdata;
   logic mgmt_rd_valid, mgmt_addr_hit;
   logic [2:0] charge_pump_current, osc_manual_sel;
   logic [1:0] series_resistor_sel, loop_cap_sel;
   logic second_pole_sel, lol_release_mode, time_digital_conv_off, crystal_only_synth;
   logic lock_count_width, lock_manual_override, xtal_doubler_off, ref_input0_off;
   logic ref_input1_off, digital_loop_off, modulator_off, calib_hold;
   logic manual_lock_active, osc_code_reserved, free_run_hint;
   logic [4:0] lock_manual_value, lock_ctrl_value, lock_count_bits;
   logic [3:0] output_off, pump_current_steps;
   pcpd_osc_t manual_osc;
   int n_errors = 0;
   int total_checks = 0;
   int seed = 87960;
   logic [7:0] mdl [0:8];
   logic [8:0] exp_q [$];
   logic [8:0] exp_rd;

   pcpd_regs u_dut (.*);

   // 40 MHz system clock
   always #12.5 sys_clk = ~sys_clk;

   // per-register write mask; reserved registers store nothing
   function automatic logic [7:0] mask_of(input logic [15:0] a);
      case (a)
         `PCPD_ADDR_ALF: mask_of = `PCPD_MASK_ALF;
         `PCPD_ADDR_LML: mask_of = `PCPD_MASK_LML;
         `PCPD_ADDR_MOL: mask_of = `PCPD_MASK_MOL;
         `PCPD_ADDR_XDB: mask_of = `PCPD_MASK_XDB;
         `PCPD_ADDR_RIP: mask_of = `PCPD_MASK_RIP;
         `PCPD_ADDR_OPC: mask_of = `PCPD_MASK_OPC;
         `PCPD_ADDR_LCP: mask_of = `PCPD_MASK_LCP;
         default: mask_of = 8'h00;
      endcase
   endfunction : mask_of

   // address picker covering the bank, both neighbours and an aliased upper byte
   function automatic logic [15:0] addr_of(input int i);
      addr_of = (i == 11) ? 16'h0168 : 16'(16'h0067 + i);
   endfunction : addr_of

   // one cycle on the management port; inputs move 2 ns after the edge
   task automatic drive(input logic [15:0] a, input logic w, input logic [7:0] d,
                        input logic r);
      logic in_bank;
      @(posedge sys_clk);
      #2;
      in_bank = (a >= 16'h0068) && (a <= 16'h0070);
      mgmt_addr = a;
      mgmt_wr_en = w;
      mgmt_wdata = d;
      mgmt_rd_en = r;
      // a read in the same cycle as a write returns the old byte
      if (r) exp_q.push_back(in_bank ? {1'b1, mdl[a - 16'h0068]} : 9'h000);
      if (w && in_bank) mdl[a - 16'h0068] = d & mask_of(a);
   endtask : drive

   task automatic idle(input int n);
      repeat (n) drive(16'h0000, 1'b0, 8'h00, 1'b0);
   endtask : idle

   task automatic do_reset;
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #2;
      rst = 1'b0;
      mdl = '{8'h8B, 8'h02, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   endtask : do_reset

   task automatic read_all;
      for (int i = 0; i < 12; i++) drive(addr_of(i), 1'b0, 8'h00, 1'b1);
      idle(2);
   endtask : read_all

   // field and derived outputs against the model, two idle cycles after the last write
   task automatic check_fields;
      idle(2);
      `PCPD_CHK("pump", mdl[0][7:5], charge_pump_current)
      `PCPD_CHK("resistor", mdl[0][4:3], series_resistor_sel)
      `PCPD_CHK("cap", mdl[0][2:1], loop_cap_sel)
      `PCPD_CHK("pole", mdl[0][0], second_pole_sel)
      `PCPD_CHK("lol_mode", mdl[1][7], lol_release_mode)
      `PCPD_CHK("tdc_off", mdl[1][4], time_digital_conv_off)
      `PCPD_CHK("xtal_synth", mdl[1][3], crystal_only_synth)
      `PCPD_CHK("cnt_width", mdl[1][1], lock_count_width)
      `PCPD_CHK("override", mdl[1][0], lock_manual_override)
      `PCPD_CHK("osc_sel", mdl[2][7:5], osc_manual_sel)
      `PCPD_CHK("lock_val", mdl[2][4:0], lock_manual_value)
      `PCPD_CHK("dbl_off", mdl[4][0], xtal_doubler_off)
      `PCPD_CHK("ref_off", mdl[5][1:0], {ref_input1_off, ref_input0_off})
      `PCPD_CHK("out_off", mdl[7][3:0], output_off)
      `PCPD_CHK("dloop_off", mdl[8][2], digital_loop_off)
      `PCPD_CHK("mod_off", mdl[8][1], modulator_off)
      `PCPD_CHK("cal_hold", mdl[8][0], calib_hold)
      `PCPD_CHK("man_act", mdl[1][0], manual_lock_active)
      `PCPD_CHK("man_osc", 3'(mdl[1][0] && (mdl[2][7:5] == 3'h1)), manual_osc)
      `PCPD_CHK("osc_rsvd", mdl[2][7:5] > 3'h1, osc_code_reserved)
      `PCPD_CHK("lock_ctl", mdl[1][0] ? mdl[2][4:0] : 5'h00, lock_ctrl_value)
      `PCPD_CHK("cnt_bits", mdl[1][1] ? 5'h10 : 5'h14, lock_count_bits)
      `PCPD_CHK("steps", 4'(mdl[0][7:5]) + 4'h1, pump_current_steps)
      `PCPD_CHK("free_run", mdl[1][3] & ~mdl[8][2], free_run_hint)
   endtask : check_fields

   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   // read monitor: each valid pulse takes the oldest expected {hit, byte}
   always @(negedge sys_clk) begin
      if (mgmt_rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("ERROR rd_valid expected 0 seen 1");
         end else begin
            // pop once; the compare macro reads its expected value twice
            exp_rd = exp_q.pop_front();
            `PCPD_CHK("rdata_hit", exp_rd, {mgmt_addr_hit, mgmt_rdata})
         end
      end
   end

   // watchdog well beyond the roughly 220 cycles the sequence needs
   initial begin
      #(25 * 4000);
      n_errors++;
      $display("ERROR watchdog expected done seen hang");
      summarize();
   end

   // main sequence
   initial begin
      logic [15:0] a;
      do_reset();
      check_fields();
      read_all();
      // byte 0x68 walk: field next cycle, derived step count one cycle later
      drive(16'h0068, 1'b1, 8'h55, 1'b0);
      idle(1);
      `PCPD_CHK("walk_pump", 3'h2, charge_pump_current)
      `PCPD_CHK("walk_steps_old", 4'h5, pump_current_steps)
      idle(1);
      `PCPD_CHK("walk_steps_new", 4'h3, pump_current_steps)
      // directed: mode readback, top pump code, manual osc one, crystal-only, reserved osc
      drive(16'h0069, 1'b1, 8'hFF, 1'b0);
      drive(16'h0069, 1'b0, 8'h00, 1'b1);
      drive(16'h0068, 1'b1, 8'hE2, 1'b0);
      drive(16'h0069, 1'b1, 8'h99, 1'b0);
      drive(16'h006A, 1'b1, 8'h2B, 1'b0);
      drive(16'h0070, 1'b1, 8'h00, 1'b0);
      check_fields();
      drive(16'h006A, 1'b1, 8'hEB, 1'b0);
      check_fields();
      // random traffic, reserved bits and reserved registers included
      for (int round = 0; round < 4; round++) begin
         for (int k = 0; k < 25; k++) begin
            a = addr_of(int'(($random(seed) & 32'h7FFFFFFF) % 12));
            drive(a, 1'($random(seed)), 8'($random(seed)), 1'($random(seed)));
         end
         check_fields();
         read_all();
      end
      // reset in mid-run restores every default
      drive(16'h0070, 1'b1, 8'h07, 1'b0);
      idle(1);
      do_reset();
      check_fields();
      read_all();
      `PCPD_CHK("queue_empty", 0, exp_q.size())
      summarize();
   end
endmodule : pcpd_regs_bench
`undef PCPD_CHK
`default_nettype wire
